// [hw/frsc_host.sv]
// Host controller driving a parallel flash reset, command writes and
// status reads, with a Wishbone classic slave for software.
// Assumes flash pins are synchronous to clk_sys; data bus is 16 bits.
//
// Functional notes
// [RL1] Device enters reset/power-down while reset_powerdown_n is low.
// [RL2] In reset the device deselects and floats its data outputs.
// [RL3] After reset, device reads array and status equals 80h.
// [RL4] Reset low aborts erase, program or lock configuration.
// [RL5] Aborted by reset, ready_busy_out stays low until reset completes.
// [RL6] Host holds reset low at least reset_pulse_min.
// [RL7] Host waits reset_to_write_wait before writes, reset_to_read_wait before reads.
// [RL8] Flash reset should follow system processor reset.
// [RL9] Program-enable supply in lockout allows only reads.
// [RL10] Commands go in by bus writes to the command_interface.
// [RL11] Altering commands use setup then immediate confirm write.
// [RL12] Status reads show status on low byte, 00h on high byte.
// [RL13] Error bits stay set until the clear-status command.
// [RL14] No page-mode reads in status mode; one access each.
// [RL15] Status latched on OE/CE fall; host toggles OE before next read.
// [RL16] Read-status works whatever the program-enable supply.
// [RL17] Bit 7 zero busy with bits 6..0 invalid; one ready.
// [RL18] Bit 6 shows erase suspend.
// [RL19] Bits 5:4 encode success, program, erase, sequence error.
// [RL20] Bit 3 flags supply out of limits, operation aborted.
// [RL21] Bit 2 shows program suspend.
// [RL22] Bit 1 flags locked block; bit 0 reserved.
// [RL23] Clear-status also selects status-read mode.
// [RL24] Program, erase or lock start selects status-read mode.
`timescale 1ns/1ns
`default_nettype none
module frsc_host
    import frsc_pkg::*;
#(
    parameter int RESET_PULSE = RESET_PULSE_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             reset_powerdown_n,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             program_enable_supply,
    output logic [15:0]      dq_o,
    output logic             dq_oe,
    input  wire logic [15:0] dq_i,
    input  wire logic        ready_busy_out
);
    import frsc_pkg::*;

    typedef struct packed {
        frsc_state_type st;
        logic           rst_req;
        logic           pen;
        logic [16:0]    cmd;
        logic           go;
        logic           rd_go;
        logic           err;
        logic [7:0]     sr;
        logic [15:0]    rdata;
        logic           rst_n;
        logic           ce_n;
        logic           oe_n;
        logic           we_n;
        logic [15:0]    dq;
        logic           dq_oe;
        logic [31:0]    wb_dat;
        logic           wb_ack;
        logic           tload;
        logic [15:0]    tval;
    } frsc_regs_type;

    frsc_regs_type r_ff, nxt_r;
    logic          t_done;

    frsc_timer #(.W(16)) u_timer (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .load     (r_ff.tload),
        .load_val (r_ff.tval),
        .done     (t_done)
    );

    // Commands that alter the array, needing the supply enabled
    function automatic logic is_alter(input logic [7:0] c);
        return (c == 8'h20) || (c == 8'h40) || (c == 8'h10) || (c == 8'hE8)
            || (c == 8'h60);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_r        = r_ff;
        nxt_r.tload  = 1'b0;
        nxt_r.tval   = '0;
        nxt_r.wb_ack = 1'b0;
        // Wishbone slave; one wait cycle, ack drops after one cycle
        if (wb_cyc_i && wb_stb_i && !r_ff.wb_ack) begin
            nxt_r.wb_ack = 1'b1;
            nxt_r.wb_dat = '0;
            if (wb_we_i) begin
                case (wb_adr_i)
                    REG_CTRL: begin
                        if (wb_sel_i[0]) begin
                            nxt_r.rst_req = wb_dat_i[CTRL_RESET_BIT];
                            nxt_r.pen     = wb_dat_i[CTRL_PEN_BIT];
                        end
                    end
                    REG_CMD: begin
                        if (r_ff.st == FRSC_IDLE) begin
                            nxt_r.cmd = wb_dat_i[16:0];
                            // Lockout: altering commands refused by host
                            if (is_alter(wb_dat_i[7:0]) && !r_ff.pen) begin // RL9
                                nxt_r.err = 1'b1;
                            end else begin
                                nxt_r.go  = 1'b1;
                                nxt_r.err = 1'b0;
                            end
                        end
                    end
                    REG_RDATA: begin
                        if (r_ff.st == FRSC_IDLE) begin
                            nxt_r.rd_go = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (wb_adr_i)
                    REG_CTRL:   nxt_r.wb_dat = {30'h0, r_ff.pen, r_ff.rst_req};
                    REG_CMD:    nxt_r.wb_dat = {15'h0, r_ff.cmd};
                    REG_STATUS: nxt_r.wb_dat = {16'h0, r_ff.sr, 4'h0, r_ff.err,
                                    ready_busy_out, !r_ff.rst_n,
                                    r_ff.st != FRSC_IDLE};
                    REG_RDATA:  nxt_r.wb_dat = {16'h0, r_ff.rdata};
                    default:    nxt_r.wb_dat = '0;
                endcase
            end
        end
        case (r_ff.st)
            FRSC_IDLE: begin
                if (r_ff.rst_req) begin
                    // Reset aborts any running operation in the flash
                    nxt_r.st    = FRSC_RST; // RL4
                    nxt_r.rst_n = 1'b0; // RL1
                    nxt_r.tload = 1'b1;
                    nxt_r.tval  = 16'(RESET_PULSE);
                end else if (r_ff.go) begin
                    nxt_r.go    = 1'b0;
                    nxt_r.st    = FRSC_WR1; // RL10
                    nxt_r.ce_n  = 1'b0;
                    nxt_r.we_n  = 1'b0;
                    nxt_r.dq    = {8'h00, r_ff.cmd[7:0]};
                    nxt_r.dq_oe = 1'b1;
                    nxt_r.tload = 1'b1;
                    nxt_r.tval  = 16'(STROBE_CYC);
                end else if (r_ff.rd_go) begin
                    nxt_r.rd_go = 1'b0;
                    // Single access per read, OE falls fresh each time
                    nxt_r.st    = FRSC_RD; // RL14
                    nxt_r.ce_n  = 1'b0;
                    nxt_r.oe_n  = 1'b0; // RL15
                    nxt_r.tload = 1'b1;
                    nxt_r.tval  = 16'(STROBE_CYC);
                end
            end
            FRSC_RST: begin
                // Hold reset for the minimum pulse
                if (t_done && !r_ff.rst_req) begin // RL6
                    nxt_r.st    = FRSC_WAKE;
                    nxt_r.rst_n = 1'b1;
                    nxt_r.sr    = SR_RESET_VALUE; // RL3
                    nxt_r.tload = 1'b1;
                    nxt_r.tval  = 16'(WRITE_WAIT_CYC > READ_WAIT_CYC ?
                                      WRITE_WAIT_CYC : READ_WAIT_CYC);
                end
            end
            FRSC_WAKE: begin
                if (t_done) begin // RL7
                    nxt_r.st = FRSC_IDLE;
                end
            end
            FRSC_WR1: begin
                if (t_done) begin
                    nxt_r.ce_n  = 1'b1;
                    nxt_r.we_n  = 1'b1;
                    nxt_r.st    = r_ff.cmd[CMD_TWO_BIT] ? FRSC_GAP : FRSC_RDGAP;
                    nxt_r.tload = 1'b1;
                    nxt_r.tval  = 16'(STROBE_CYC);
                end
            end
            FRSC_GAP: begin
                // Confirm follows setup with nothing in between
                if (t_done) begin // RL11
                    nxt_r.st    = FRSC_WR2;
                    nxt_r.ce_n  = 1'b0;
                    nxt_r.we_n  = 1'b0;
                    nxt_r.dq    = {8'h00, r_ff.cmd[15:8]};
                    nxt_r.tload = 1'b1;
                    nxt_r.tval  = 16'(STROBE_CYC);
                end
            end
            FRSC_WR2: begin
                if (t_done) begin
                    nxt_r.ce_n  = 1'b1;
                    nxt_r.we_n  = 1'b1;
                    nxt_r.st    = FRSC_RDGAP;
                    nxt_r.tload = 1'b1;
                    nxt_r.tval  = 16'(STROBE_CYC);
                end
            end
            FRSC_RD: begin
                nxt_r.dq_oe = 1'b0;
                if (t_done) begin
                    nxt_r.rdata = dq_i;
                    // Status sits on the low byte
                    nxt_r.sr    = dq_i[7:0]; // RL12
                    nxt_r.ce_n  = 1'b1;
                    nxt_r.oe_n  = 1'b1;
                    nxt_r.st    = FRSC_RDGAP;
                    nxt_r.tload = 1'b1;
                    nxt_r.tval  = 16'(STROBE_CYC);
                end
            end
            FRSC_RDGAP: begin
                nxt_r.dq_oe = 1'b0;
                if (t_done) begin
                    nxt_r.st = FRSC_IDLE;
                end
            end
            default: nxt_r.st = FRSC_IDLE;
        endcase
        if (r_ff.rst_req && r_ff.st != FRSC_RST && r_ff.st != FRSC_IDLE) begin
            nxt_r.st    = FRSC_RST;
            nxt_r.rst_n = 1'b0;
            nxt_r.ce_n  = 1'b1;
            nxt_r.oe_n  = 1'b1;
            nxt_r.we_n  = 1'b1;
            nxt_r.dq_oe = 1'b0;
            nxt_r.tload = 1'b1;
            nxt_r.tval  = 16'(RESET_PULSE);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            // Flash reset asserted with system reset so boot reads array
            r_ff       <= '0; // RL8
            r_ff.st    <= FRSC_RST;
            r_ff.tload <= 1'b1;
            r_ff.tval  <= 16'(RESET_PULSE);
            r_ff.ce_n  <= 1'b1;
            r_ff.oe_n  <= 1'b1;
            r_ff.we_n  <= 1'b1;
            r_ff.sr    <= SR_RESET_VALUE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign wb_dat_o              = r_ff.wb_dat;
    assign wb_ack_o              = r_ff.wb_ack;
    assign reset_powerdown_n     = r_ff.rst_n;
    assign ce_n                  = r_ff.ce_n;
    assign oe_n                  = r_ff.oe_n;
    assign we_n                  = r_ff.we_n;
    assign program_enable_supply = r_ff.pen;
    assign dq_o                  = r_ff.dq;
    assign dq_oe                 = r_ff.dq_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [15:0] low_cnt_ff;
    always_ff @(posedge clk_sys) begin
        if (srst || r_ff.rst_n) begin
            low_cnt_ff <= '0;
        end else if (low_cnt_ff != 16'hFFFF) begin
            low_cnt_ff <= low_cnt_ff + 16'h0001;
        end
    end

    a_reset_pulse_len: assert property (@(posedge clk_sys) disable iff (srst) // RL6
        $rose(r_ff.rst_n) |-> low_cnt_ff >= 16'(RESET_PULSE))
        else $error("reset pulse too short");
    a_wake_no_write: assert property (@(posedge clk_sys) disable iff (srst) // RL7
        $rose(r_ff.rst_n) |-> r_ff.we_n [*8])
        else $error("write too soon after reset");
    a_reset_floats: assert property (@(posedge clk_sys) disable iff (srst) // RL2
        !r_ff.rst_n |-> !r_ff.dq_oe && r_ff.ce_n)
        else $error("bus driven during reset");
    a_sr_after_reset: assert property (@(posedge clk_sys) disable iff (srst) // RL3
        $rose(r_ff.rst_n) |-> r_ff.sr == SR_RESET_VALUE)
        else $error("status not preset after reset");
    a_confirm_follows: assert property (@(posedge clk_sys) disable iff (srst) // RL11
        (r_ff.st == FRSC_GAP) |-> ##[1:20] (r_ff.st == FRSC_WR2) || !r_ff.rst_n)
        else $error("confirm write missing");
    a_lockout_block: assert property (@(posedge clk_sys) disable iff (srst) // RL9
        (r_ff.st == FRSC_WR1) |-> r_ff.pen || !is_alter(r_ff.cmd[7:0]))
        else $error("altering command in lockout");
    a_read_oe_rise: assert property (@(posedge clk_sys) disable iff (srst) // RL15
        $fell(r_ff.oe_n) |-> $past(r_ff.oe_n, 2))
        else $error("oe not toggled between reads");
    a_write_data_on: assert property (@(posedge clk_sys) disable iff (srst) // RL10
        !r_ff.we_n |-> r_ff.dq_oe && !r_ff.ce_n && r_ff.oe_n)
        else $error("write without driven data");
endmodule
`default_nettype wire

// [hw/frsc_pkg.sv]
// Package for the flash reset/status host controller.
// Assumes a 100 MHz system clock and a Wishbone classic register port.
package frsc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_CMD    = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_RDATA  = 4'hC;
    // CTRL fields
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_PEN_BIT   = 1;
    // CMD fields: [7:0] first code, [15:8] confirm code, bit16 two-cycle
    localparam int CMD_TWO_BIT    = 16;
    // STATUS fields
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_INRST_BIT   = 1;
    localparam int ST_RDY_BIT     = 2;
    localparam int ST_ERR_BIT     = 3;
    localparam int ST_SR_LSB      = 8;
    // ------------------------------------------------------------
    // Device command codes and status layout
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_READ_STATUS  = 8'h70;
    localparam logic [7:0] CODE_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] SR_RESET_VALUE    = 8'h80;
    localparam int SR_READY = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_ERR  = 5;
    localparam int SR_PROG_ERR   = 4;
    localparam int SR_VPP_ERR    = 3;
    localparam int SR_PROG_SUSP  = 2;
    localparam int SR_LOCK_ERR   = 1;
    // ------------------------------------------------------------
    // Timing (ns) and derived cycle counts at 100 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS          = 10;
    localparam int RESET_PULSE_MIN_NS     = 25000;
    localparam int RESET_TO_WRITE_WAIT_NS = 210;
    localparam int RESET_TO_READ_WAIT_NS  = 210;
    localparam int BUS_STROBE_NS          = 80;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_WAIT_CYC =
        (RESET_TO_WRITE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_WAIT_CYC =
        (RESET_TO_READ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC =
        (BUS_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        FRSC_IDLE  = 3'b000,
        FRSC_RST   = 3'b001,
        FRSC_WAKE  = 3'b010,
        FRSC_WR1   = 3'b011,
        FRSC_GAP   = 3'b100,
        FRSC_WR2   = 3'b101,
        FRSC_RD    = 3'b110,
        FRSC_RDGAP = 3'b111
    } frsc_state_type;
endpackage

// [hw/frsc_timer.sv]
// Down-counter used for reset pulse, wake-up and strobe timing.
// Assumes one clock; load has priority over counting.
`timescale 1ns/1ns
`default_nettype none
module frsc_timer #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign done = (cnt_ff == '0) && !load;
endmodule
`default_nettype wire

// [testbench/frsc_flash_model.sv]
// Behavioural parallel flash: reset/power-down, command entry, status.
// Assumes one host drives strobes and write data from a clocked engine.
`timescale 1ns/1ns
`default_nettype none
module frsc_flash_model #(
    parameter int          PULSE_NS = 40,
    parameter int          WAIT_NS  = 210,
    parameter int          BUSY_NS  = 2000,
    parameter int          RDY_NS   = 100,
    parameter logic [15:0] ARRAY_W  = 16'h5AC3
) (
    input  wire logic        reset_powerdown_n,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        program_enable_supply,
    input  wire logic [15:0] dq_o,
    input  wire logic        dq_oe,
    input  wire logic        lock_on,
    output logic [15:0]      dq_i,
    output logic             ready_busy_out,
    output int               host_viol,
    output int               wr_count
);
    logic [7:0]  op_stat = 8'h80;
    logic [7:0]  op_lat = 8'h80;
    logic [7:0]  setup = 8'h00;
    logic [15:0] wd;
    logic        woe, wce;
    logic        stat_mode = 1'b0;
    logic        busy = 1'b0;
    logic        await = 1'b0;
    logic        abrt = 1'b0;
    time         t_fall = 0, t_rise = 0, t_done = 0, t_rdy = 0;

    initial begin
        dq_i = 16'h0000;
        ready_busy_out = 1'b0;
        host_viol = 0;
        wr_count = 0;
    end
    always @(negedge reset_powerdown_n) begin
        t_fall = $time;
        abrt = busy;
        busy = 1'b0;
        await = 1'b0;
    end
    always @(posedge reset_powerdown_n) begin
        if ($time - t_fall < PULSE_NS) host_viol++;
        t_rise = $time;
        t_rdy = abrt ? $time + RDY_NS : 0;
        stat_mode = 1'b0;
        op_stat = 8'h80;
    end
    // Ticks on even ns so the pin never moves on a rising host clock edge
    always begin
        #2;
        // No suspend support: both suspend flags stay clear
        op_stat[6] = 1'b0;
        op_stat[2] = 1'b0;
        if (busy && $time >= t_done) begin
            busy = 1'b0;
            op_stat[7] = 1'b1;
        end
        ready_busy_out = reset_powerdown_n && !busy && $time >= t_rdy;
    end
    // Sampled just after the strobe falls: the host may release all at once
    always @(negedge we_n) begin
        #1;
        wd = dq_o;
        woe = dq_oe;
        wce = !ce_n;
    end
    always @(posedge we_n) if (wce && reset_powerdown_n) begin
        wr_count++;
        if ($time - t_rise < WAIT_NS || !woe || wd[15:8] !== 8'h00) host_viol++;
        if (await) begin
            await = 1'b0;
            if (setup == 8'h20 && wd[7:0] != 8'hD0) op_stat[5:4] = 2'b11;
            else if (!program_enable_supply) op_stat[3] = 1'b1;
            else if (lock_on) op_stat |= (setup == 8'h20) ? 8'h22 : 8'h12;
            else begin
                busy = 1'b1;
                op_stat[7] = 1'b0;
                t_done = $time + BUSY_NS;
            end
        end else begin
            case (wd[7:0])
                8'h70: stat_mode = 1'b1;
                8'h50: begin
                    op_stat &= 8'hC5;
                    stat_mode = 1'b1;
                end
                8'hFF: stat_mode = 1'b0;
                8'h20, 8'h40, 8'h10, 8'hE8, 8'h60: begin
                    await = 1'b1;
                    setup = wd[7:0];
                    stat_mode = 1'b1;
                end
                default: ;
            endcase
        end
    end
    always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) begin
        if (!reset_powerdown_n || $time - t_rise < WAIT_NS) host_viol++;
        op_lat = op_stat;
    end
    always @(ce_n, oe_n, reset_powerdown_n, op_lat, stat_mode) begin
        if (!ce_n && !oe_n && reset_powerdown_n) begin
            if (!stat_mode) dq_i = ARRAY_W;
            else if (op_lat[7]) dq_i = {8'h00, op_lat};
            else dq_i = {8'h00, 1'b0, ~dq_i[6:0]};
        end else begin
            dq_i = ~dq_i;
        end
    end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the flash reset/status host controller.
// Assumes the behavioural flash model on the far side of the strobes.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import frsc_pkg::*;
    localparam logic [15:0] ARR = 16'h5AC3;
    localparam logic [39:0] ALT = 40'h20_40_10_E8_60;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, lock_on = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic        ack, reset_powerdown_n, ce_n, oe_n, we_n, pen, dq_oe, rb;
    logic [15:0] dq_o, dq_i;
    int          host_viol, wr_count, wc, bad_count = 0, checks_done = 0, cycles = 0;

    frsc_host #(.RESET_PULSE(4)) i_frsc_host (.clk_sys(clk_sys), .srst(srst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
        .reset_powerdown_n(reset_powerdown_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .program_enable_supply(pen), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
        .ready_busy_out(rb));
    frsc_flash_model #(.ARRAY_W(ARR)) i_frsc_flash_model (
        .reset_powerdown_n(reset_powerdown_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .program_enable_supply(pen), .dq_o(dq_o), .dq_oe(dq_oe), .lock_on(lock_on),
        .dq_i(dq_i), .ready_busy_out(rb), .host_viol(host_viol), .wr_count(wr_count));

    initial forever #5 clk_sys = ~clk_sys;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            $display("mismatch run_length expected finish seen hang");
            report_and_stop;
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 100);
        rd = rdat;
        check("wb_ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            wb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[b] !== v && n < 2000);
        check("status poll", {31'h0, v}, {31'h0, rd[b]});
    endtask
    task automatic cmd(input logic [7:0] s, input logic [7:0] c, input logic two);
        wb(1'b1, REG_CMD, {15'h0, two, c, s});
        poll(ST_BUSY_BIT, 1'b0);
    endtask
    task automatic fread(input string what, input logic [15:0] exp);
        wb(1'b1, REG_RDATA, 32'h0);
        poll(ST_BUSY_BIT, 1'b0);
        wb(1'b0, REG_RDATA, 32'h0);
        check(what, {16'h0, exp}, {16'h0, rd[15:0]});
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        poll(ST_INRST_BIT, 1'b0);
        poll(ST_BUSY_BIT, 1'b0);
        poll(ST_RDY_BIT, 1'b1);
        fread("array word", ARR);
        cmd(8'h70, 8'h00, 1'b0);
        fread("status word", 16'h0080);
        fread("status reread", 16'h0080);
        $display("test boot done");
        wc = wr_count;
        for (int i = 0; i < 5; i++) begin
            cmd(ALT[8*i +: 8], 8'hD0, 1'b1);
            wb(1'b0, REG_STATUS, 32'h0);
            check("refused flag", 32'h1, {31'h0, rd[ST_ERR_BIT]});
        end
        check("lockout writes", wc, wr_count);
        $display("test lockout done");
        wb(1'b1, REG_CTRL, 32'h2);
        cmd(8'h20, 8'hD0, 1'b1);
        check("pair writes", wc + 2, wr_count);
        wb(1'b0, REG_CMD, 32'h0);
        check("cmd readback", 32'h0001_D020, rd);
        wb(1'b0, REG_STATUS, 32'h0);
        check("busy pin", 32'h0, {31'h0, rd[ST_RDY_BIT]});
        wb(1'b1, REG_RDATA, 32'h0);
        poll(ST_BUSY_BIT, 1'b0);
        wb(1'b0, REG_RDATA, 32'h0);
        check("busy status", 32'h0, {23'h0, rd[15:7]});
        poll(ST_RDY_BIT, 1'b1);
        fread("done status", 16'h0080);
        $display("test erase done");
        lock_on <= 1'b1;
        cmd(8'h40, 8'h12, 1'b1);
        fread("lock error", 16'h0092);
        fread("sticky error", 16'h0092);
        lock_on <= 1'b0;
        cmd(8'h50, 8'h00, 1'b0);
        fread("cleared", 16'h0080);
        cmd(8'h20, 8'h00, 1'b1);
        fread("sequence error", 16'h00B0);
        cmd(8'h50, 8'h00, 1'b0);
        $display("test errors done");
        cmd(8'h20, 8'hD0, 1'b1);
        wb(1'b1, REG_CTRL, 32'h3);
        wb(1'b0, REG_STATUS, 32'h0);
        check("abort pins", 32'h1, {30'h0, rd[ST_RDY_BIT:ST_INRST_BIT]});
        wb(1'b0, REG_CTRL, 32'h0);
        check("ctrl readback", 32'h3, rd);
        wb(1'b1, REG_CTRL, 32'h2);
        poll(ST_INRST_BIT, 1'b0);
        poll(ST_BUSY_BIT, 1'b0);
        fread("array after abort", ARR);
        poll(ST_RDY_BIT, 1'b1);
        cmd(8'h70, 8'h00, 1'b0);
        fread("status after abort", 16'h0080);
        $display("test abort done");
        wb(1'b1, REG_CTRL, 32'h0);
        cmd(8'hFF, 8'h00, 1'b0);
        fread("array again", ARR);
        cmd(8'h70, 8'h00, 1'b0);
        fread("status in lockout", 16'h0080);
        wb(1'b0, 4'h2, 32'h0);
        check("unmapped read", 32'h0, rd);
        wb(1'b1, 4'h2, 32'hFFFF_FFFF);
        wb(1'b0, REG_CTRL, 32'h0);
        check("unmapped write", 32'h0, rd);
        check("host timing", 32'h0, host_viol);
        $display("test misc done");
        report_and_stop;
    end
endmodule
`default_nettype wire
